// File: core/scs_pkg.sv
package scs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_TXDATA = 8'h04;
    localparam logic [7:0] OFF_RXDATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;

    // Control field positions
    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_MASTER   = 1;
    localparam int CTRL_POL      = 2;
    localparam int CTRL_STOP_LO  = 3;
    localparam int CTRL_SRC      = 5;
    localparam int CTRL_DIV_LO   = 8;
    localparam int DIV_W         = 8;

    // Status field positions
    localparam int STAT_BUSY     = 0;
    localparam int STAT_RX_FULL  = 1;
    localparam int STAT_TX_EMPTY = 2;
    localparam int STAT_CFG_ERR  = 3;
    localparam int STAT_TXC_DIR  = 4;
    localparam int STAT_TXS_DIR  = 5;
    localparam int STAT_RXC_DIR  = 6;
    localparam int STAT_RXS_DIR  = 7;
    localparam int STAT_RXS_POL  = 8;
    localparam int STAT_TXS_POL  = 9;
    localparam int STAT_SRCLK    = 10;

    // Reset values: CPU clock source, divide value one
    localparam logic [31:0] CTRL_RESET = 32'h0000_0120;

    // Clock-stop codes
    localparam logic [1:0] STOP_NO_DELAY   = 2'b10;
    localparam logic [1:0] STOP_HALF_DELAY = 2'b11;

    // Slave divide value and source
    localparam logic [DIV_W-1:0] SLAVE_DIV = 8'h01;
    localparam logic             SRC_CPU   = 1'b1;

    // Timing: one unit of 2H is one CPU clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_UNIT_NS  = 5;
    localparam int UNIT_CYCLES   = (2 * HALF_UNIT_NS) / CLK_PERIOD_NS;

    localparam int LEN_W = 10;

    typedef struct packed {
        logic [DIV_W-1:0] rate_divide_value;
        logic [1:0]       spare;           // Gap below the divide field
        logic             rate_gen_source_sel;
        logic [1:0]       clock_stop_select;
        logic             tx_clock_polarity;
        logic             master;
        logic             enable;
    } scs_cfg_t;

    typedef struct packed {
        logic [LEN_W-1:0] low_len;
        logic [LEN_W-1:0] high_len;
    } scs_phase_t;

    // Serial clock phase lengths in CPU cycles
    function automatic scs_phase_t scs_phase_of(input logic [DIV_W-1:0] div);
        scs_phase_t       p;
        logic [LEN_W-1:0] d;
        d = LEN_W'(div);
        if (div == '0) begin
            p.low_len  = LEN_W'(UNIT_CYCLES);
            p.high_len = LEN_W'(UNIT_CYCLES);
        end else if (div[0]) begin
            p.low_len  = LEN_W'(((d + 1) >> 1) * LEN_W'(UNIT_CYCLES));
            p.high_len = LEN_W'(((d + 1) >> 1) * LEN_W'(UNIT_CYCLES));
        end else begin
            p.low_len  = LEN_W'((d >> 1) * LEN_W'(UNIT_CYCLES));
            p.high_len = LEN_W'(((d >> 1) + 1) * LEN_W'(UNIT_CYCLES));
        end
        return p;
    endfunction

endpackage

// File: core/scs_port.sv
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Every slave setup uses the CPU clock source and divide one.
// - The generated clock period is divide plus one units of 2H, or two units for a divide of zero.
// - Low phase is half the period for odd or zero, else div/2 units.
// - High phase is half the period for odd or zero, else div/2+1.
// - Both frame-sync polarity controls are set to one.
// - As master the transmit frame sync goes out as active-low select.
// - As slave the received active-low selects are inverted for use.
// - Master drives transmit clock and sync, receives clock and sync.
// - Slave takes all four clock and sync lines as inputs.
// - Select is low before the rising edge that starts the transfer.
// - Output bits are launched on the falling clock edge.
// - Input bits are captured on the rising clock edge.
// - Select leads by one period (11b) or one high phase (10b).
// - Master 11b releases data out at the falling edge after last bit.
// - Slave 10b releases data out once the select returns high.
// - Slave drives the first bit as soon as the select falls.
module scs_port
    import scs_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_serial_clock_pin_i,
    output logic             tx_serial_clock_pin_o,
    output logic             tx_serial_clock_pin_oe_n,
    input  wire logic        tx_frame_sync_pin_i,
    output logic             tx_frame_sync_pin_o,
    output logic             tx_frame_sync_pin_oe_n,
    input  wire logic        rx_frame_sync_pin_i,
    input  wire logic        serial_data_in_pin,
    output logic             serial_data_out_pin_o,
    output logic             serial_data_out_pin_oe_n
);

    localparam int BIT_W = $clog2(WORD_W + 1);
    localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_W);

    typedef enum logic [2:0] {
        ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL, ST_SLAVE
    } scs_state_t;

    scs_state_t        state_q, state_d;
    scs_cfg_t          cfg_q, cfg_d;
    scs_phase_t        phase;
    logic              srclk;
    logic [WORD_W-1:0] tx_word_q, tx_word_d;
    logic [WORD_W-1:0] rx_word_q, rx_word_d;
    logic [WORD_W-1:0] shift_q, shift_d;
    logic              tx_full_q, tx_full_d;
    logic              rx_full_q, rx_full_d;
    logic [BIT_W-1:0]  bits_q, bits_d;
    logic [LEN_W-1:0]  cnt_q, cnt_d;
    logic              sclk_q, sclk_d;
    logic              sclk_oe_n_q, sclk_oe_n_d;
    logic              fs_q, fs_d;
    logic              fs_oe_n_q, fs_oe_n_d;
    logic              dout_q, dout_d;
    logic              doe_n_q, doe_n_d;
    logic              sclk_prev_q, sclk_prev_d;
    logic              sel_prev_q, sel_prev_d;
    logic [31:0]       prdata_q, prdata_d;
    logic              pready_q, pready_d;
    logic              pslverr_q, pslverr_d;

    logic              mode_ok, cfg_err, active, busy;
    logic              wr_en, rd_en, setup;
    logic              sel_act, s_rise, s_fall, rx_done;
    logic [31:0]       status;

    // Shared rate generator with phase lengths
    scs_rate_gen u_rate (
        .clk                 (clk),
        .arst_n              (arst_n),
        .cfg                 (cfg_q),
        .phase_q             (phase),
        .sample_rate_clock_q (srclk)
    );

    // Configuration checks
    assign mode_ok = (cfg_q.clock_stop_select == STOP_HALF_DELAY
                      && !cfg_q.tx_clock_polarity)
                  || (cfg_q.clock_stop_select == STOP_NO_DELAY
                      && cfg_q.tx_clock_polarity);
    assign cfg_err = cfg_q.enable && (!mode_ok || (!cfg_q.master
                  && (cfg_q.rate_gen_source_sel != SRC_CPU
                      || cfg_q.rate_divide_value != SLAVE_DIV)));
    assign active  = cfg_q.enable && !cfg_err;
    assign busy    = (state_q != ST_IDLE && state_q != ST_SLAVE)
                  || (state_q == ST_SLAVE && sel_prev_q);

    // Slave select inverted from both sync pins; edges of external clock
    assign sel_act = !tx_frame_sync_pin_i || !rx_frame_sync_pin_i;
    assign s_rise  = tx_serial_clock_pin_i && !sclk_prev_q;
    assign s_fall  = !tx_serial_clock_pin_i && sclk_prev_q;

    // Status word, direction and polarity fields included
    always_comb begin
        status                = '0;
        status[STAT_BUSY]     = busy;
        status[STAT_RX_FULL]  = rx_full_q;
        status[STAT_TX_EMPTY] = !tx_full_q;
        status[STAT_CFG_ERR]  = cfg_err;
        status[STAT_TXC_DIR]  = cfg_q.master;
        status[STAT_TXS_DIR]  = cfg_q.master;
        status[STAT_RXC_DIR]  = 1'b0;
        status[STAT_RXS_DIR]  = 1'b0;
        status[STAT_RXS_POL]  = 1'b1;
        status[STAT_TXS_POL]  = 1'b1;
        status[STAT_SRCLK]    = srclk;
    end

    // APB slave: answer in the access cycle, no wait states
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_q && pwrite;
    assign rd_en = psel && penable && pready_q && !pwrite;

    always_comb begin
        pready_d  = setup;
        pslverr_d = setup && !(paddr == OFF_CTRL || paddr == OFF_TXDATA
                    || paddr == OFF_RXDATA || paddr == OFF_STATUS);
        prdata_d  = '0;
        if (setup && !pwrite) begin
            unique case (paddr)
                OFF_CTRL:   prdata_d = 32'(cfg_q);
                OFF_RXDATA: prdata_d = 32'(rx_word_q);
                OFF_STATUS: prdata_d = status;
                default:    prdata_d = '0;
            endcase
        end else if (psel && penable) begin
            prdata_d = prdata_q;
        end
    end

    // Serial engine and register updates
    always_comb begin
        state_d     = state_q;
        cfg_d       = cfg_q;
        tx_word_d   = tx_word_q;
        rx_word_d   = rx_word_q;
        shift_d     = shift_q;
        tx_full_d   = tx_full_q;
        rx_full_d   = rx_full_q;
        bits_d      = bits_q;
        cnt_d       = cnt_q;
        sclk_d      = sclk_q;
        sclk_oe_n_d = !(cfg_q.master && cfg_q.enable);
        fs_d        = fs_q;
        fs_oe_n_d   = !(cfg_q.master && cfg_q.enable);
        dout_d      = dout_q;
        doe_n_d     = doe_n_q;
        sclk_prev_d = tx_serial_clock_pin_i;
        sel_prev_d  = sel_act;
        rx_done     = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                sclk_d = cfg_q.tx_clock_polarity;
                fs_d   = 1'b1;
                if (active && cfg_q.master && tx_full_q) begin
                    shift_d   = tx_word_q;
                    tx_full_d = 1'b0;
                    fs_d      = 1'b0;
                    dout_d    = tx_word_q[WORD_W-1];
                    doe_n_d   = 1'b0;
                    bits_d    = '0;
                    // Lead: full period for 11b, high phase for 10b
                    cnt_d = cfg_q.tx_clock_polarity ? phase.high_len
                          : LEN_W'(phase.low_len + phase.high_len);
                    state_d = ST_LEAD;
                end else if (active && !cfg_q.master) begin
                    sel_prev_d = 1'b0;
                    state_d    = ST_SLAVE;
                end
            end
            ST_LEAD: begin
                cnt_d = cnt_q - 10'h001;
                if (cnt_q <= 10'h001) begin
                    if (!cfg_q.tx_clock_polarity) begin
                        sclk_d  = 1'b1;
                        shift_d = {shift_q[WORD_W-2:0], serial_data_in_pin};
                        bits_d  = bits_q + 1'b1;
                        cnt_d   = phase.high_len;
                        state_d = ST_HIGH;
                    end else begin
                        sclk_d  = 1'b0;              // First fall, bit stays
                        cnt_d   = phase.low_len;
                        state_d = ST_LOW;
                    end
                end
            end
            ST_LOW: begin
                cnt_d = cnt_q - 10'h001;
                if (cnt_q <= 10'h001) begin
                    sclk_d  = 1'b1;
                    shift_d = {shift_q[WORD_W-2:0], serial_data_in_pin};
                    bits_d  = bits_q + 1'b1;
                    cnt_d   = phase.high_len;
                    state_d = ST_HIGH;
                end
            end
            ST_HIGH: begin
                cnt_d = cnt_q - 10'h001;
                if (cnt_q <= 10'h001) begin
                    if (bits_q == LAST_BIT) begin
                        rx_done = 1'b1;
                        doe_n_d = 1'b1;
                        if (!cfg_q.tx_clock_polarity) begin
                            sclk_d  = 1'b0;
                            cnt_d   = phase.low_len;
                            state_d = ST_TAIL;
                        end else begin
                            fs_d    = 1'b1;
                            state_d = ST_IDLE;
                        end
                    end else begin
                        sclk_d  = 1'b0;
                        dout_d  = shift_q[WORD_W-1];
                        cnt_d   = phase.low_len;
                        state_d = ST_LOW;
                    end
                end
            end
            ST_TAIL: begin
                cnt_d = cnt_q - 10'h001;
                if (cnt_q <= 10'h001) begin
                    fs_d    = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_SLAVE: begin
                if (sel_act && !sel_prev_q) begin
                    shift_d   = tx_full_q ? tx_word_q : '0;
                    tx_full_d = 1'b0;
                    dout_d    = tx_full_q && tx_word_q[WORD_W-1];
                    doe_n_d   = 1'b0;
                    bits_d    = '0;
                end else if (sel_act) begin
                    if (s_rise && bits_q != LAST_BIT) begin
                        shift_d = {shift_q[WORD_W-2:0], serial_data_in_pin};
                        bits_d  = bits_q + 1'b1;
                    end else if (s_fall && bits_q != '0
                                 && bits_q != LAST_BIT) begin
                        dout_d = shift_q[WORD_W-1];
                    end
                end else if (sel_prev_q) begin
                    doe_n_d = 1'b1;
                    rx_done = (bits_q == LAST_BIT);
                end
                if (!active || cfg_q.master) begin
                    doe_n_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
        endcase
        if (rx_done) begin
            rx_word_d = shift_d;
        end
        // Reading RX data clears the flag; a new word wins over the clear
        if (rd_en && paddr == OFF_RXDATA) begin
            rx_full_d = 1'b0;
        end
        if (rx_done) begin
            rx_full_d = 1'b1;
        end
        if (wr_en && paddr == OFF_CTRL) begin
            cfg_d       = scs_cfg_t'(pwdata[CTRL_DIV_LO+DIV_W-1:0]);
            cfg_d.spare = 2'b00;            // Gap bits read as zero
        end
        if (wr_en && paddr == OFF_TXDATA) begin
            tx_word_d = pwdata[WORD_W-1:0];
            tx_full_d = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= ST_IDLE;
            cfg_q       <= scs_cfg_t'(CTRL_RESET[CTRL_DIV_LO+DIV_W-1:0]);
            tx_word_q   <= '0;
            rx_word_q   <= '0;
            shift_q     <= '0;
            tx_full_q   <= 1'b0;
            rx_full_q   <= 1'b0;
            bits_q      <= '0;
            cnt_q       <= '0;
            sclk_q      <= 1'b0;
            sclk_oe_n_q <= 1'b1;
            fs_q        <= 1'b1;
            fs_oe_n_q   <= 1'b1;
            dout_q      <= 1'b0;
            doe_n_q     <= 1'b1;
            sclk_prev_q <= 1'b0;
            sel_prev_q  <= 1'b0;
            prdata_q    <= '0;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
        end else begin
            state_q     <= state_d;
            cfg_q       <= cfg_d;
            tx_word_q   <= tx_word_d;
            rx_word_q   <= rx_word_d;
            shift_q     <= shift_d;
            tx_full_q   <= tx_full_d;
            rx_full_q   <= rx_full_d;
            bits_q      <= bits_d;
            cnt_q       <= cnt_d;
            sclk_q      <= sclk_d;
            sclk_oe_n_q <= sclk_oe_n_d;
            fs_q        <= fs_d;
            fs_oe_n_q   <= fs_oe_n_d;
            dout_q      <= dout_d;
            doe_n_q     <= doe_n_d;
            sclk_prev_q <= sclk_prev_d;
            sel_prev_q  <= sel_prev_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
        end
    end

    // Outputs straight from flops
    assign prdata                   = prdata_q;
    assign pready                   = pready_q;
    assign pslverr                  = pslverr_q;
    assign tx_serial_clock_pin_o    = sclk_q;
    assign tx_serial_clock_pin_oe_n = sclk_oe_n_q;
    assign tx_frame_sync_pin_o      = fs_q;
    assign tx_frame_sync_pin_oe_n   = fs_oe_n_q;
    assign serial_data_out_pin_o    = dout_q;
    assign serial_data_out_pin_oe_n = doe_n_q;

endmodule

`default_nettype wire

// File: core/scs_rate_gen.sv
`timescale 1ns/100ps
`default_nettype none

module scs_rate_gen
    import scs_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   arst_n,
    input  wire scs_cfg_t cfg,
    output scs_phase_t  phase_q,
    output logic        sample_rate_clock_q
);

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             srclk_d;
    scs_phase_t       phase_d;

    // Divide CPU clock by divide value plus one; phase lengths per divide
    always_comb begin
        phase_d = scs_phase_of(cfg.rate_divide_value);
        cnt_d   = cnt_q;
        srclk_d = sample_rate_clock_q;
        if (cfg.rate_gen_source_sel == SRC_CPU) begin
            if (cnt_q >= cfg.rate_divide_value) begin
                cnt_d   = '0;
                srclk_d = 1'b1;
            end else begin
                cnt_d   = cnt_q + 8'h01;
                srclk_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q               <= '0;
            sample_rate_clock_q <= 1'b0;
            phase_q             <= '0;
        end else begin
            cnt_q               <= cnt_d;
            sample_rate_clock_q <= srclk_d;
            phase_q             <= phase_d;
        end
    end

endmodule

`default_nettype wire

// File: sim/scs_port_chk.sv
`timescale 1ns/100ps
`default_nettype none
module scs_port_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tx_serial_clock_pin_o,
    input wire logic tx_serial_clock_pin_oe_n,
    input wire logic tx_frame_sync_pin_i,
    input wire logic tx_frame_sync_pin_o,
    input wire logic tx_frame_sync_pin_oe_n,
    input wire logic rx_frame_sync_pin_i,
    input wire logic serial_data_out_pin_o,
    input wire logic serial_data_out_pin_oe_n
);
    // Short aliases for the watched pins
    wire logic sc   = tx_serial_clock_pin_o;
    wire logic mst  = !tx_serial_clock_pin_oe_n;
    wire logic fs   = tx_frame_sync_pin_o;
    wire logic fsi  = tx_frame_sync_pin_i;
    wire logic dout = serial_data_out_pin_o;
    wire logic doe  = serial_data_out_pin_oe_n;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Frame starts and the first clock edge that follows
    sequence lead0_s;
        mst && $fell(fs) && !sc;
    endsequence
    sequence lead1_s;
        mst && $fell(fs) && sc;
    endsequence
    sequence first_rise_s;
        !sc ##[1:4] $rose(sc);
    endsequence
    sequence first_fall_s;
        sc ##[1:4] $fell(sc);
    endsequence

    dir_pair_a: assert property (tx_serial_clock_pin_oe_n == tx_frame_sync_pin_oe_n)
        else $error("clock and select directions differ");
    sel_active_a: assert property (mst && !doe |-> !fs)
        else $error("data driven while select high");
    idle_clk_a: assert property (mst && $past(mst) && fs && $past(fs) |-> $stable(sc))
        else $error("clock moved outside a frame");
    launch_fall_a: assert property (mst && !doe && !$past(doe) && !$stable(dout) |-> $fell(sc))
        else $error("data changed off a falling clock");
    release_a: assert property (mst && $rose(doe) |-> $fell(sc) || $rose(fs))
        else $error("data released at wrong moment");
    lead0_a: assert property (lead0_s |=> first_rise_s)
        else $error("select lead wrong, polarity 0");
    lead1_a: assert property (lead1_s |-> first_fall_s)
        else $error("select lead wrong, polarity 1");
    slave_drive_a: assert property (!mst && $fell(fsi) && rx_frame_sync_pin_i |-> ##[1:2] !doe)
        else $error("slave did not drive after select");
    slave_release_a: assert property (!mst && $rose(fsi) && !doe |-> ##[1:2] doe)
        else $error("slave kept driving after select");
endmodule

bind scs_port scs_port_chk chk (
    .clk(clk), .arst_n(arst_n),
    .tx_serial_clock_pin_o(tx_serial_clock_pin_o),
    .tx_serial_clock_pin_oe_n(tx_serial_clock_pin_oe_n),
    .tx_frame_sync_pin_i(tx_frame_sync_pin_i),
    .tx_frame_sync_pin_o(tx_frame_sync_pin_o),
    .tx_frame_sync_pin_oe_n(tx_frame_sync_pin_oe_n),
    .rx_frame_sync_pin_i(rx_frame_sync_pin_i),
    .serial_data_out_pin_o(serial_data_out_pin_o),
    .serial_data_out_pin_oe_n(serial_data_out_pin_oe_n));
`default_nettype wire

// File: sim/scs_spi_peer.sv
`timescale 1ns/100ps
`default_nettype none
module scs_spi_peer (
    input  wire logic        sclk,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    input  wire logic [15:0] tx_word,
    output logic             miso,
    output logic [15:0]      rx_word
);
    logic [15:0] sh        = '0;
    logic        rose_seen = 1'b0;
    logic        last      = 1'b0;

    // Load word when selected
    always @(negedge sel_n) begin
        sh        <= tx_word;
        rose_seen <= 1'b0;
    end
    // Capture on each rise while selected
    always @(posedge sclk) begin
        if (!sel_n) begin
            rx_word   <= {rx_word[14:0], mosi};
            rose_seen <= 1'b1;
        end
    end
    // Next bit on falls after the first rise
    always @(negedge sclk) begin
        if (!sel_n && rose_seen)
            sh <= {sh[14:0], 1'b0};
    end
    always @(posedge sel_n) last <= sh[15];
    // Bit stands ahead of each rise; released line shows inverse
    assign miso = sel_n ? ~last : sh[15];
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import scs_pkg::*;
    logic        clk, arst_n, psel, penable, pwrite, tb_sc, tb_fs, tb_d;
    logic        tb_rfs;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, sc_o, sc_oe_n, fs_o, fs_oe_n, d_o, d_oe_n;
    logic [15:0] peer_word, peer_rx;
    logic        sc_prev;
    int          miscompares, checks_done, cyc, run, hi_len, lo_len;
    wire logic   peer_miso;
    // Pin levels from all parties
    wire logic   sc_pin = sc_oe_n ? tb_sc : sc_o;
    wire logic   fs_pin = fs_oe_n ? tb_fs : fs_o;
    wire logic   din    = sc_oe_n ? tb_d : peer_miso;

    scs_port dut (
        .clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_serial_clock_pin_i(sc_pin), .tx_serial_clock_pin_o(sc_o),
        .tx_serial_clock_pin_oe_n(sc_oe_n), .tx_frame_sync_pin_i(fs_pin),
        .tx_frame_sync_pin_o(fs_o), .tx_frame_sync_pin_oe_n(fs_oe_n),
        .rx_frame_sync_pin_i(tb_rfs), .serial_data_in_pin(din),
        .serial_data_out_pin_o(d_o), .serial_data_out_pin_oe_n(d_oe_n));
    scs_spi_peer peer (
        .sclk(sc_pin), .sel_n(fs_pin), .mosi(d_o), .tx_word(peer_word),
        .miso(peer_miso), .rx_word(peer_rx));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    // Phase lengths of the serial clock within a frame
    always @(negedge clk) begin
        if (!fs_pin && sc_pin !== sc_prev) begin
            if (sc_prev) hi_len = run;
            else lo_len = run;
            run = 1;
        end else begin
            run = run + 1;
        end
        sc_prev = sc_pin;
    end

    task automatic check(input string n, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic conclude;
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, wd, r, e);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a,
                         input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(n, r, exp);
    endtask

    task automatic reset_scn;
        logic [31:0] r;
        logic        e;
        check("reset oe", {sc_oe_n, fs_oe_n, d_oe_n}, 3'h7);
        rdchk("ctrl reset", OFF_CTRL, CTRL_RESET);
        apb(1'b0, 8'h10, 32'h0, r, e);
        check("unmapped err", e, 1'b1);
        check("unmapped data", r, 32'h0);
        wr(OFF_CTRL, 32'h0000_0235);
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        check("slave div err", r[STAT_CFG_ERR], 1'b1);
    endtask
    // Master frame with the peer answering
    task automatic master_run(input logic [31:0] ctrl, input logic [15:0] txw,
                              input logic [15:0] pw, input int hi, lo);
        logic [31:0] r;
        logic        e;
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, ctrl);
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        check("master dirs", r[9:4], 6'h33);
        peer_word = pw;
        wr(OFF_TXDATA, {16'h0, txw});
        do
            apb(1'b0, OFF_STATUS, 32'h0, r, e);
        while (r[STAT_BUSY] !== 1'b0);
        check("peer rx", peer_rx, txw);
        rdchk("rx word", OFF_RXDATA, {16'h0, pw});
        check("high len", hi_len, hi);
        check("low len", lo_len, lo);
        check("data oe", d_oe_n, 1'b1);
        check("select end", fs_o, 1'b1);
    endtask
    task automatic master_scn;
        master_run(32'h0000_013b, 16'h1234, 16'ha5c3, 1, 1);
        master_run(32'h0000_0237, 16'h8001, 16'h0ff1, 2, 1);
        master_run(32'h0000_033b, 16'h7e81, 16'h5a5a, 2, 2);
        master_run(32'h0000_0437, 16'hc001, 16'h3c3c, 3, 2);
    endtask
    // Slave frame driven by the bench as master, 16-cycle clock
    task automatic slave_scn;
        logic [31:0] r;
        logic        e;
        logic [15:0] got;
        logic [15:0] sin;
        sin = 16'h5a3c;
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, 32'h0000_0135);
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        check("slave dirs", r[9:4], 6'h30);
        wr(OFF_TXDATA, 32'h0000_c3a5);
        @(posedge clk) tb_fs <= 1'b0;
        repeat (3) @(posedge clk);
        check("first bit", {d_oe_n, d_o}, 2'h1);
        for (int i = 15; i >= 0; i--) begin
            tb_sc <= 1'b0;
            tb_d <= sin[i];
            repeat (8) @(posedge clk);
            got[i] = d_o;
            tb_sc <= 1'b1;
            repeat (8) @(posedge clk);
        end
        tb_fs <= 1'b1;
        repeat (3) @(posedge clk);
        check("slave release", d_oe_n, 1'b1);
        check("slave out", got, 16'hc3a5);
        // Select through the second sync pin, empty TX sends zeros
        tb_rfs <= 1'b0;
        repeat (3) @(posedge clk);
        check("rx pin select", {d_oe_n, d_o}, 2'h0);
        tb_rfs <= 1'b1;
        repeat (3) @(posedge clk);
        check("rx pin release", d_oe_n, 1'b1);
        rdchk("slave rx", OFF_RXDATA, 32'h0000_5a3c);
    endtask

    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {tb_sc, tb_fs, tb_d} = 3'h6;
        tb_rfs = 1'b1;
        {miscompares, checks_done, cyc, run, hi_len, lo_len} = '0;
        sc_prev = 1'b0;
        peer_word = 16'h0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        reset_scn();
        master_scn();
        slave_scn();
        conclude();
    end
endmodule
`default_nettype wire
